// *** cgc_pkg.sv ***
// constants and types shared by the counter gate and compare logic
package cgc_pkg;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HI = 8'h04;
  localparam logic [7:0] OFS_LO = 8'h08;
  localparam logic [7:0] OFS_START = 8'h0C;
  localparam logic [7:0] OFS_CMP0 = 8'h10;
  localparam logic [7:0] OFS_CMP1 = 8'h14;
  localparam logic [7:0] OFS_DICFG = 8'h18;
  localparam logic [7:0] OFS_DQCFG = 8'h1C;
  localparam logic [7:0] OFS_HYST = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_COUNT = 8'h28;
  // control fields
  localparam int CTRL_SWGATE = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_OPP = 2;
  localparam int CTRL_GCONT = 3;
  localparam int CTRL_ZSYNC = 4;
  localparam int DI_STRIDE = 4;
  localparam int DI_POL = 3;
  localparam int DI_DELAY = 8;
  localparam int DQ_STRIDE = 16;
  localparam int DQ_DIR = 3;
  localparam int DQ_MS = 8;
  localparam logic [31:0] HI_RESET = 32'h01FF_FFFF;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int DELAY_NS = 50000;
  localparam int DELAY_CYC = (DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  // ****************************************
  // encodings
  // ****************************************
  localparam logic [2:0] DI_NONE = 3'h0;
  localparam logic [2:0] DI_LVL = 3'h1;
  localparam logic [2:0] DI_START = 3'h2;
  localparam logic [2:0] DI_STOP = 3'h3;
  localparam logic [2:0] DI_SYNC = 3'h4;
  localparam logic [2:0] DI_ZMEN = 3'h5;
  localparam logic [2:0] DQ_NONE = 3'h0;
  localparam logic [2:0] DQ_UPPER = 3'h1;
  localparam logic [2:0] DQ_LOWER = 3'h2;
  localparam logic [2:0] DQ_WINDOW = 3'h3;
  localparam logic [2:0] DQ_PULSE = 3'h4;
  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_COUNT = 3'b010,
    ST_HALT = 3'b100
  } cgc_st_type;
endpackage

// *** cgc_di.sv ***
// aux input synchroniser, debounce and edge detect
module cgc_di (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic pin,
  input wire logic delay_on,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [10:0] cnt;
    logic rise;
    logic fall;
  } cgc_di_type;
  cgc_di_type r_reg, r_next;

  always_comb begin
    r_next = r_reg;
    r_next.s1 = pin;
    r_next.s2 = r_reg.s1;
    r_next.rise = 1'b0;
    r_next.fall = 1'b0;
    if (r_reg.s2 == r_reg.lvl) begin
      r_next.cnt = 11'h000;
    end else if (!delay_on || r_reg.cnt == 11'(cgc_pkg::DELAY_CYC)) begin
      // accepted only once stable longer than the delay [R13]
      r_next.lvl = r_reg.s2;
      r_next.rise = r_reg.s2;
      r_next.fall = !r_reg.s2;
      r_next.cnt = 11'h000;
    end else begin
      r_next.cnt = r_reg.cnt + 11'h001;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign level = r_reg.lvl;
  assign rise = r_reg.rise;
  assign fall = r_reg.fall;

  property p_debounce;
    @(posedge mclk) disable iff (!arst_n)
    (delay_on && $changed(r_reg.lvl)) |-> $past(r_reg.cnt) == 11'(cgc_pkg::DELAY_CYC);
  endproperty
  a_debounce: assert property (p_debounce) else $error("input accepted too early"); // [R13]
endmodule

// *** cgc_dq.sv ***
// one switched output: band, window and pulse compare with hysteresis
module cgc_dq (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [2:0] fn,
  input wire logic [1:0] dir,
  input wire logic [7:0] ms,
  input wire logic [31:0] cnt,
  input wire logic [31:0] lo,
  input wire logic [31:0] hi,
  input wire logic [31:0] cmp_a,
  input wire logic [31:0] cmp_b,
  input wire logic [15:0] hyst,
  input wire logic evt,
  input wire logic up,
  input wire logic tick,
  output logic q
);
  typedef struct packed {
    logic q;
    logic lock;
    logic [7:0] timer;
  } cgc_dq_type;
  cgc_dq_type r_reg, r_next;
  logic dir_ok, band, in_h, want;

  // hysteresis range is clipped at the counting limits
  function automatic logic near(input logic [31:0] c, input logic [31:0] v);
    logic [31:0] a;
    logic [31:0] b;
    a = (c > lo + 32'(hyst)) ? c - 32'(hyst) : lo;
    b = (c + 32'(hyst) < hi) ? c + 32'(hyst) : hi;
    near = (v >= a) && (v <= b);
  endfunction

  always_comb begin
    r_next = r_reg;
    dir_ok = (dir == cgc_pkg::DIR_BOTH) || (dir == cgc_pkg::DIR_UP && up) ||
      (dir == cgc_pkg::DIR_DOWN && !up); // [R21]
    in_h = (hyst != 16'h0000) &&
      (near(cmp_a, cnt) || (fn == cgc_pkg::DQ_WINDOW && near(cmp_b, cnt))); // [R22]
    r_next.lock = r_reg.lock && in_h;
    case (fn)
      cgc_pkg::DQ_UPPER: band = (cmp_a <= cnt) && (cnt <= hi); // [R16]
      cgc_pkg::DQ_LOWER: band = (lo <= cnt) && (cnt <= cmp_a); // [R17]
      cgc_pkg::DQ_WINDOW: band = (cmp_a <= cnt) && (cnt <= cmp_b); // [R18]
      default: band = 1'b0;
    endcase
    want = (fn == cgc_pkg::DQ_WINDOW && !(evt && dir_ok)) ? r_reg.q : band;
    case (fn)
      cgc_pkg::DQ_UPPER, cgc_pkg::DQ_LOWER, cgc_pkg::DQ_WINDOW: begin
        if (want != r_reg.q && !r_reg.lock) begin
          r_next.q = want;
          r_next.lock = in_h; // [R22]
        end
      end
      cgc_pkg::DQ_PULSE: begin
        if (evt && dir_ok && cnt == cmp_a && !r_reg.lock) begin
          r_next.q = 1'b1; // [R19]
          r_next.timer = ms;
          r_next.lock = in_h;
        end else if (r_reg.q && r_reg.timer == 8'h00) begin
          // zero duration: held until the next count pulse
          r_next.q = !evt; // [R19]
        end else if (r_reg.q && tick) begin
          // first millisecond may be short by up to one tick period
          r_next.timer = r_reg.timer - 8'h01;
          r_next.q = r_reg.timer != 8'h01;
        end
      end
      default: begin
        r_next.q = 1'b0; // [R20]
        r_next.lock = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.q;

  property p_none_low;
    @(posedge mclk) disable iff (!arst_n)
    (fn == cgc_pkg::DQ_NONE) |=> !q;
  endproperty
  a_none_low: assert property (p_none_low) else $error("output without function not low"); // [R20]

  sequence s_pulse_hit;
    fn == cgc_pkg::DQ_PULSE && evt && dir_ok && cnt == cmp_a && !r_reg.lock;
  endsequence
  property p_pulse_on;
    @(posedge mclk) disable iff (!arst_n)
    s_pulse_hit |=> q && r_reg.timer == $past(ms);
  endproperty
  a_pulse_on: assert property (p_pulse_on) else $error("pulse did not start"); // [R19]
endmodule

// *** cgc_top.sv ***
// counter with gate control, limit reaction, aux inputs and switched outputs
// How it works
// R1 - stop reaction: limit violation stops counting and closes internal gate
// R2 - after a limit stop, counting resumes only after gate close and reopen
// R3 - continue reaction: counting goes on after a limit violation
// R4 - on violation counter loads start value or opposite limit per reset option
// R5 - gate opening loads start value or continues from last value
// R6 - gate-start reaction applies only when a hardware gate is configured
// R7 - level gate input holds hardware gate open while active, closed otherwise
// R8 - edge gate-start or gate-stop input opens or closes hardware gate
// R9 - sync input edge loads start value into counter
// R10 - zero-mark enable input permits zero-mark sync only while active
// R11 - input without function does nothing but its level is reported
// R12 - software assigns each input function to at most one input
// R13 - input change accepted only after stable longer than shared delay
// R14 - level functions use configured active level, high or low
// R15 - edge functions use configured rising or falling edge
// R16 - upper band: output active when comparison <= count <= high limit
// R17 - lower band: output active when low limit <= count <= comparison
// R18 - window on output 1 only, with output 0 unused; cmp0 <= count <= cmp1
// R19 - pulse mode: on match output active for set ms, zero until next pulse
// R20 - output with no function is always driven low
// R21 - window and pulse switch only in configured count direction
// R22 - hysteresis range blocks re-switching until count leaves it; 0 disables
// R23 - software keeps high limit within 25 bits and above low limit
// R24 - internal gate open only when software and configured hardware gate open
module cgc_top #(
  parameter int MS_CYCLES = cgc_pkg::MS_CYC
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_pulse,
  input wire logic count_up,
  input wire logic zero_mark,
  input wire logic aux_input_0,
  input wire logic aux_input_1,
  output logic switch_output_0,
  output logic switch_output_1
);
  typedef struct packed {
    cgc_pkg::cgc_st_type st;
    logic [31:0] ctrl;
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] start;
    logic [31:0] cmp0;
    logic [31:0] cmp1;
    logic [31:0] dicfg;
    logic [31:0] dqcfg;
    logic [15:0] hyst;
    logic [31:0] cnt;
    logic dir;
    logic evt;
    logic hardware_gate;
    logic [23:0] div;
    logic tick;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } cgc_state_type;
  cgc_state_type r_reg, r_next;

  logic [1:0] di_lvl, di_rise, di_fall, di_act, di_edge;
  logic [1:0] pin_in, q_out;
  logic [1:0] is_lvl, is_start, is_stop, is_sync, is_zm;
  logic hw_cfg, gate, viol, sync_evt, zm_ok;
  logic [31:0] rd_mux;
  logic [2:0] dq_fn [2];
  logic [31:0] dq_a [2];

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [1:0] fn_is(input logic [31:0] cfg, input logic [2:0] code);
    for (int k = 0; k < 2; k++) begin
      fn_is[k] = cfg[k * cgc_pkg::DI_STRIDE +: 3] == code;
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      cgc_pkg::OFS_CTRL, cgc_pkg::OFS_HI, cgc_pkg::OFS_LO, cgc_pkg::OFS_START,
      cgc_pkg::OFS_CMP0, cgc_pkg::OFS_CMP1, cgc_pkg::OFS_DICFG, cgc_pkg::OFS_DQCFG,
      cgc_pkg::OFS_HYST, cgc_pkg::OFS_STATUS, cgc_pkg::OFS_COUNT: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ****************************************
  // aux inputs
  // ****************************************
  assign pin_in = {aux_input_1, aux_input_0};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_di
      cgc_di u_di (
        .mclk(mclk),
        .arst_n(arst_n),
        .pin(pin_in[gi]),
        .delay_on(r_reg.dicfg[cgc_pkg::DI_DELAY]),
        .level(di_lvl[gi]),
        .rise(di_rise[gi]),
        .fall(di_fall[gi])
      );
      // polarity bit: 1 = active low / falling edge
      assign di_act[gi] = di_lvl[gi] ^ r_reg.dicfg[gi * cgc_pkg::DI_STRIDE + cgc_pkg::DI_POL]; // [R14]
      assign di_edge[gi] = r_reg.dicfg[gi * cgc_pkg::DI_STRIDE + cgc_pkg::DI_POL] ?
        di_fall[gi] : di_rise[gi]; // [R15]
    end
  endgenerate

  // inputs sharing a function are ORed; software keeps them unique [R12]
  assign is_lvl = fn_is(r_reg.dicfg, cgc_pkg::DI_LVL);
  assign is_start = fn_is(r_reg.dicfg, cgc_pkg::DI_START);
  assign is_stop = fn_is(r_reg.dicfg, cgc_pkg::DI_STOP);
  assign is_sync = fn_is(r_reg.dicfg, cgc_pkg::DI_SYNC);
  assign is_zm = fn_is(r_reg.dicfg, cgc_pkg::DI_ZMEN);
  assign hw_cfg = |(is_lvl | is_start | is_stop);
  assign gate = r_reg.ctrl[cgc_pkg::CTRL_SWGATE] && (!hw_cfg || r_reg.hardware_gate); // [R24]
  assign sync_evt = |(is_sync & di_edge); // [R9]
  assign zm_ok = r_reg.ctrl[cgc_pkg::CTRL_ZSYNC] && zero_mark &&
    (!(|is_zm) || |(is_zm & di_act)); // [R10]
  assign viol = count_up ? (r_reg.cnt == r_reg.hi) : (r_reg.cnt == r_reg.lo);

  // ****************************************
  // register read mux
  // ****************************************
  always_comb begin
    case (paddr)
      cgc_pkg::OFS_CTRL: rd_mux = r_reg.ctrl;
      cgc_pkg::OFS_HI: rd_mux = r_reg.hi;
      cgc_pkg::OFS_LO: rd_mux = r_reg.lo;
      cgc_pkg::OFS_START: rd_mux = r_reg.start;
      cgc_pkg::OFS_CMP0: rd_mux = r_reg.cmp0;
      cgc_pkg::OFS_CMP1: rd_mux = r_reg.cmp1;
      cgc_pkg::OFS_DICFG: rd_mux = r_reg.dicfg;
      cgc_pkg::OFS_DQCFG: rd_mux = r_reg.dqcfg;
      cgc_pkg::OFS_HYST: rd_mux = {16'h0000, r_reg.hyst};
      // unassigned inputs still reported; internal gate reads closed when halted [R1]
      cgc_pkg::OFS_STATUS: rd_mux = {24'h000000, q_out, r_reg.st == cgc_pkg::ST_HALT,
        r_reg.hardware_gate, r_reg.st == cgc_pkg::ST_COUNT, r_reg.dir, di_lvl}; // [R11]
      cgc_pkg::OFS_COUNT: rd_mux = r_reg.cnt;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    r_next = r_reg;
    r_next.evt = 1'b0;
    r_next.tick = r_reg.div == 24'(MS_CYCLES - 1);
    r_next.div = r_next.tick ? 24'h000000 : r_reg.div + 24'h000001;
    // hardware gate; stop edge wins over a simultaneous start edge
    if (|is_lvl) begin
      r_next.hardware_gate = |(is_lvl & di_act); // [R7]
    end else if (|(is_stop & di_edge)) begin
      r_next.hardware_gate = 1'b0; // [R8]
    end else if (|(is_start & di_edge)) begin
      r_next.hardware_gate = 1'b1; // [R8]
    end
    case (r_reg.st)
      cgc_pkg::ST_IDLE: begin
        if (gate) begin
          r_next.st = cgc_pkg::ST_COUNT;
          if (hw_cfg && !r_reg.ctrl[cgc_pkg::CTRL_GCONT]) begin // [R6]
            r_next.cnt = r_reg.start; // [R5]
          end
        end
      end
      cgc_pkg::ST_COUNT: begin
        if (!gate) begin
          r_next.st = cgc_pkg::ST_IDLE;
        end else if (count_pulse) begin
          r_next.dir = count_up;
          r_next.evt = 1'b1;
          if (viol) begin
            if (r_reg.ctrl[cgc_pkg::CTRL_OPP]) begin
              r_next.cnt = count_up ? r_reg.lo : r_reg.hi; // [R4]
            end else begin
              r_next.cnt = r_reg.start; // [R4]
            end
            if (r_reg.ctrl[cgc_pkg::CTRL_STOP]) begin
              r_next.st = cgc_pkg::ST_HALT; // [R1]
            end
          end else begin
            r_next.cnt = count_up ? r_reg.cnt + 32'h1 : r_reg.cnt - 32'h1; // [R3]
          end
        end
      end
      cgc_pkg::ST_HALT: begin
        // only a closed gate releases the stop
        if (!gate) begin
          r_next.st = cgc_pkg::ST_IDLE; // [R2]
        end
      end
      default: r_next.st = cgc_pkg::ST_IDLE;
    endcase
    if (sync_evt || zm_ok) begin
      r_next.cnt = r_reg.start; // [R9]
    end
    // apb slave: one wait state, answer registered
    r_next.rdy = 1'b0;
    r_next.err = 1'b0;
    if (psel && penable && !r_reg.rdy) begin
      r_next.rdy = 1'b1;
      r_next.err = !mapped(paddr);
      r_next.rdata = (pwrite || !mapped(paddr)) ? 32'h0000_0000 : rd_mux;
    end
    if (psel && penable && r_reg.rdy && pwrite) begin
      case (paddr)
        cgc_pkg::OFS_CTRL: r_next.ctrl = pwdata;
        cgc_pkg::OFS_HI: r_next.hi = pwdata;
        cgc_pkg::OFS_LO: r_next.lo = pwdata;
        cgc_pkg::OFS_START: r_next.start = pwdata;
        cgc_pkg::OFS_CMP0: r_next.cmp0 = pwdata;
        cgc_pkg::OFS_CMP1: r_next.cmp1 = pwdata;
        cgc_pkg::OFS_DICFG: r_next.dicfg = pwdata;
        cgc_pkg::OFS_DQCFG: r_next.dqcfg = pwdata;
        cgc_pkg::OFS_HYST: r_next.hyst = pwdata[15:0];
        default: r_next.rdy = 1'b0;
      endcase
      r_next.rdy = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      r_reg <= '0;
      r_reg.st <= cgc_pkg::ST_IDLE;
      r_reg.hi <= cgc_pkg::HI_RESET;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************
  // switched outputs
  // ****************************************
  always_comb begin
    dq_fn[0] = (r_reg.dqcfg[2:0] == cgc_pkg::DQ_WINDOW) ? cgc_pkg::DQ_NONE : r_reg.dqcfg[2:0];
    dq_fn[1] = r_reg.dqcfg[cgc_pkg::DQ_STRIDE +: 3];
    if (dq_fn[1] == cgc_pkg::DQ_WINDOW && r_reg.dqcfg[2:0] != cgc_pkg::DQ_NONE) begin
      dq_fn[1] = cgc_pkg::DQ_NONE; // [R18]
    end
    dq_a[0] = r_reg.cmp0;
    dq_a[1] = (dq_fn[1] == cgc_pkg::DQ_WINDOW) ? r_reg.cmp0 : r_reg.cmp1;
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_dq
      cgc_dq u_dq (
        .mclk(mclk),
        .arst_n(arst_n),
        .fn(dq_fn[gi]),
        .dir(r_reg.dqcfg[gi * cgc_pkg::DQ_STRIDE + cgc_pkg::DQ_DIR +: 2]),
        .ms(r_reg.dqcfg[gi * cgc_pkg::DQ_STRIDE + cgc_pkg::DQ_MS +: 8]),
        .cnt(r_reg.cnt),
        .lo(r_reg.lo),
        .hi(r_reg.hi),
        .cmp_a(dq_a[gi]),
        .cmp_b(r_reg.cmp1),
        .hyst(r_reg.hyst),
        .evt(r_reg.evt),
        .up(r_reg.dir),
        .tick(r_reg.tick),
        .q(q_out[gi])
      );
    end
  endgenerate

  assign switch_output_0 = q_out[0];
  assign switch_output_1 = q_out[1];
  assign prdata = r_reg.rdata;
  assign pready = r_reg.rdy;
  assign pslverr = r_reg.err;

  // ****************************************
  // checks
  // ****************************************
  sequence s_viol;
    r_reg.st == cgc_pkg::ST_COUNT && gate && count_pulse && viol && !sync_evt && !zm_ok;
  endsequence
  property p_stop;
    @(posedge mclk) disable iff (!arst_n)
    (s_viol and r_reg.ctrl[cgc_pkg::CTRL_STOP]) |=> r_reg.st == cgc_pkg::ST_HALT;
  endproperty
  a_stop: assert property (p_stop) else $error("limit stop missed"); // [R1]
  property p_halt_hold;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == cgc_pkg::ST_HALT && gate) |=> r_reg.st == cgc_pkg::ST_HALT;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("restart without gate cycle"); // [R2]
  property p_continue;
    @(posedge mclk) disable iff (!arst_n)
    (s_viol and !r_reg.ctrl[cgc_pkg::CTRL_STOP] && !r_reg.ctrl[cgc_pkg::CTRL_OPP]) |=>
      r_reg.st == cgc_pkg::ST_COUNT && r_reg.cnt == $past(r_reg.start);
  endproperty
  a_continue: assert property (p_continue) else $error("continue reload wrong"); // [R3]
  property p_opposite;
    @(posedge mclk) disable iff (!arst_n)
    (s_viol and r_reg.ctrl[cgc_pkg::CTRL_OPP] && count_up) |=> r_reg.cnt == $past(r_reg.lo);
  endproperty
  a_opposite: assert property (p_opposite) else $error("opposite limit not loaded"); // [R4]
  property p_gate_close;
    @(posedge mclk) disable iff (!arst_n)
    (r_reg.st == cgc_pkg::ST_COUNT && !gate) |=> r_reg.st == cgc_pkg::ST_IDLE;
  endproperty
  a_gate_close: assert property (p_gate_close) else $error("count with gate closed"); // [R24]
  property p_sync;
    @(posedge mclk) disable iff (!arst_n)
    sync_evt |=> r_reg.cnt == $past(r_reg.start);
  endproperty
  a_sync: assert property (p_sync) else $error("sync did not load start"); // [R9]
  property p_level_gate;
    @(posedge mclk) disable iff (!arst_n)
    (is_lvl[0] && di_act[0]) |=> r_reg.hardware_gate;
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("level gate not open"); // [R7]
endmodule

// *** cgc_enc_model.sv ***
// encoder front end and field input model for the counter bench
module cgc_enc_model (
  input wire logic mclk,
  output logic count_pulse,
  output logic count_up,
  output logic zero_mark,
  output logic aux_input_0,
  output logic aux_input_1
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    count_pulse = 1'b0;
    count_up = 1'b1;
    zero_mark = 1'b0;
    aux_input_0 = 1'b0;
    aux_input_1 = 1'b0;
  end
  // ****************************************
  // stimulus tasks
  // ****************************************
  // one single-cycle pulse per count, gaps leave room for the compare stage
  task automatic step(input int n, input logic up);
    repeat (n) begin
      @(posedge mclk);
      count_pulse <= 1'b1;
      count_up <= up;
      @(posedge mclk);
      count_pulse <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    repeat (3) @(posedge mclk);
  endtask
  task automatic zmark;
    @(posedge mclk);
    zero_mark <= 1'b1;
    @(posedge mclk);
    zero_mark <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  task automatic set_aux(input int k, input logic v);
    @(posedge mclk);
    if (k == 0) aux_input_0 <= v;
    else aux_input_1 <= v;
    repeat (8) @(posedge mclk);
  endtask
endmodule

// *** cgc_top_tb.sv ***
// self-checking bench for the counter gate and compare logic
module cgc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 10;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic count_pulse, count_up, zero_mark, aux_input_0, aux_input_1;
  logic switch_output_0, switch_output_1;
  int error_cnt = 0;
  int check_count = 0;
  cgc_top #(.MS_CYCLES(MSC)) u_cgc_top (.mclk(mclk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_pulse(count_pulse), .count_up(count_up),
    .zero_mark(zero_mark), .aux_input_0(aux_input_0), .aux_input_1(aux_input_1),
    .switch_output_0(switch_output_0), .switch_output_1(switch_output_1));
  cgc_enc_model u_cgc_enc_model (.mclk(mclk), .count_pulse(count_pulse),
    .count_up(count_up), .zero_mark(zero_mark), .aux_input_0(aux_input_0),
    .aux_input_1(aux_input_1));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // ****************************************
  // compare and bus tasks
  // ****************************************
  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask
  // request held until pready is sampled high, bounded by a local limit
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) chk1("pready", 1'b1, pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rdm(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(nm, ex, r & m);
  endtask
  task automatic rdc(input logic [31:0] ex);
    rdm("count", cgc_pkg::OFS_COUNT, 32'hFFFF_FFFF, ex);
  endtask
  task automatic outs(input logic e0, input logic e1);
    chk1("switch_output_0", e0, switch_output_0);
    chk1("switch_output_1", e1, switch_output_1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rdm("hi reset", cgc_pkg::OFS_HI, 32'hFFFF_FFFF, cgc_pkg::HI_RESET);
    apb(1'b0, 8'h3C, 32'h0, r, e);
    chk1("unmapped error", 1'b1, e);
    wr(cgc_pkg::OFS_COUNT, 32'h0000_0007);
    rdc(32'h0000_0000);
    wr(cgc_pkg::OFS_LO, 32'h0);
    wr(cgc_pkg::OFS_HI, 32'h0000_0005);
    wr(cgc_pkg::OFS_START, 32'h0000_0002);
    $display("test regs done");
  endtask
  task automatic t_limits;
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0005);
    u_cgc_enc_model.step(5, 1'b1);
    rdc(32'h0000_0005);
    u_cgc_enc_model.step(1, 1'b1);
    rdc(32'h0000_0000);
    u_cgc_enc_model.step(1, 1'b0);
    rdc(32'h0000_0005);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0001);
    u_cgc_enc_model.step(1, 1'b1);
    rdc(32'h0000_0002);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0003);
    u_cgc_enc_model.step(4, 1'b1);
    rdm("halted", cgc_pkg::OFS_STATUS, 32'h0000_0028, 32'h0000_0020);
    u_cgc_enc_model.step(2, 1'b1);
    rdc(32'h0000_0002);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0002);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0003);
    u_cgc_enc_model.step(1, 1'b1);
    rdc(32'h0000_0003);
    $display("test limits done");
  endtask
  task automatic t_outputs;
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0001);
    wr(cgc_pkg::OFS_CMP0, 32'h0000_0004);
    wr(cgc_pkg::OFS_CMP1, 32'h0000_0003);
    wr(cgc_pkg::OFS_DQCFG, 32'h0002_0001);
    u_cgc_enc_model.step(0, 1'b1);
    outs(1'b0, 1'b1);
    u_cgc_enc_model.step(1, 1'b1);
    outs(1'b1, 1'b0);
    wr(cgc_pkg::OFS_DQCFG, 32'h0000_0000);
    u_cgc_enc_model.step(0, 1'b1);
    outs(1'b0, 1'b0);
    wr(cgc_pkg::OFS_CMP0, 32'h0000_0003);
    wr(cgc_pkg::OFS_CMP1, 32'h0000_0004);
    wr(cgc_pkg::OFS_DQCFG, 32'h0003_0000);
    u_cgc_enc_model.step(1, 1'b0);
    outs(1'b0, 1'b1);
    u_cgc_enc_model.step(1, 1'b0);
    outs(1'b0, 1'b0);
    wr(cgc_pkg::OFS_DQCFG, 32'h0000_020C);
    u_cgc_enc_model.step(1, 1'b1);
    outs(1'b1, 1'b0);
    repeat (3 * MSC) @(posedge mclk);
    outs(1'b0, 1'b0);
    u_cgc_enc_model.step(1, 1'b1);
    u_cgc_enc_model.step(1, 1'b0);
    outs(1'b0, 1'b0);
    wr(cgc_pkg::OFS_HYST, 32'h0000_0001);
    wr(cgc_pkg::OFS_DQCFG, 32'h0000_0001);
    u_cgc_enc_model.step(1, 1'b0);
    outs(1'b1, 1'b0);
    u_cgc_enc_model.step(1, 1'b0);
    outs(1'b0, 1'b0);
    u_cgc_enc_model.step(2, 1'b1);
    $display("test outputs done");
  endtask
  task automatic t_aux;
    wr(cgc_pkg::OFS_DICFG, 32'h0000_0041);
    u_cgc_enc_model.step(1, 1'b1);
    rdc(32'h0000_0003);
    u_cgc_enc_model.set_aux(0, 1'b1);
    rdc(32'h0000_0002);
    rdm("status", cgc_pkg::OFS_STATUS, 32'h0000_0019, 32'h0000_0019);
    u_cgc_enc_model.step(1, 1'b1);
    u_cgc_enc_model.set_aux(1, 1'b1);
    rdc(32'h0000_0002);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0009);
    u_cgc_enc_model.step(1, 1'b1);
    wr(cgc_pkg::OFS_DICFG, 32'h0000_00B2);
    u_cgc_enc_model.set_aux(1, 1'b0);
    rdm("hardware_gate shut", cgc_pkg::OFS_STATUS, 32'h0000_0010, 32'h0000_0000);
    u_cgc_enc_model.set_aux(0, 1'b0);
    u_cgc_enc_model.set_aux(0, 1'b1);
    rdm("hardware_gate open", cgc_pkg::OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    rdc(32'h0000_0003);
    wr(cgc_pkg::OFS_DICFG, 32'h0000_0149);
    repeat (8) @(posedge mclk);
    rdm("low level", cgc_pkg::OFS_STATUS, 32'h0000_0018, 32'h0000_0000);
    u_cgc_enc_model.set_aux(1, 1'b1);
    repeat (90) @(posedge mclk);
    rdm("early di1", cgc_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0000);
    repeat (cgc_pkg::DELAY_CYC + 10) @(posedge mclk);
    rdm("late di1", cgc_pkg::OFS_STATUS, 32'h0000_0002, 32'h0000_0002);
    wr(cgc_pkg::OFS_CTRL, 32'h0000_0011);
    wr(cgc_pkg::OFS_DICFG, 32'h0000_000D);
    u_cgc_enc_model.step(1, 1'b1);
    u_cgc_enc_model.zmark();
    rdc(32'h0000_0003);
    u_cgc_enc_model.set_aux(0, 1'b0);
    u_cgc_enc_model.zmark();
    rdc(32'h0000_0002);
    $display("test aux done");
  endtask
  // ****************************************
  // sequence and verdict
  // ****************************************
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    t_regs();
    t_limits();
    t_outputs();
    t_aux();
    final_report();
  end
  // hang guard, well above the few thousand cycles the tests take
  initial begin
    #(40 * 30000);
    error_cnt++;
    final_report();
  end
endmodule
